/* rt_host_model.sv */
`timescale 1ns/100ps
module rt_host_model (
	input  wire logic        CLK,
	input  wire logic        READY,
	input  wire logic [15:0] HOST_RDATA,
	output logic             HOST_WR = 1'b0,
	output logic             HOST_RD = 1'b0,
	output logic      [15:0] HOST_ADDR = 16'h0000,
	output logic      [15:0] HOST_WDATA = 16'h0000
);
	task automatic req(input logic w, input logic [15:0] a, d, input logic wt,
		output logic [15:0] q);
		int n;
		n = 0;
		@(negedge CLK);
		while (wt && READY !== 1'b1 && n < 2000) begin
			@(negedge CLK);
			n++;
		end
		@(posedge CLK);
		HOST_WR <= w;
		HOST_RD <= !w;
		HOST_ADDR <= a;
		HOST_WDATA <= d;
		@(posedge CLK);
		HOST_WR <= 1'b0;
		HOST_RD <= 1'b0;
		// Released lines show the inverse, never a stale value
		HOST_ADDR <= ~a;
		HOST_WDATA <= ~d;
		@(negedge CLK);
		q = HOST_RDATA;
	endtask : req
endmodule : rt_host_model

/* rt_status_ctrl.sv */
`timescale 1ns/100ps
// Contract
// - With transmit inhibit enabled, a watchdog timeout on a bus blocks transmission on that bus.
// - A bus A timeout with inhibit enabled sets the bus A inhibited flag, bit 13 at 0x0017.
// - A bus B timeout with inhibit enabled sets the bus B inhibited flag, bit 12 at 0x0017.
// - With inhibit disabled, a timeout cuts the current transmission after 663 us, once only.
// - Later transmissions are inhibited only when the inhibit enable is set.
// - Unused bits 1,0 of watchdog config and 14,12,11 of master status read zero.
// - The master status register at 0x0001 clears to zero on master reset.
// - Soft reset leaves master status bit 13 alone; only bits 15 and 10 change.
// - The ready pin always equals bit 15 of master status, which is read-only.
// - Ready is low during auto-initialization, soft reset and built-in test.
// - While ready is low host writes are blocked, and the host waits for ready; the test host waits only on requests with wt set.
// - While ready is low every host read returns master status, whatever the address.
// - Status bit 13 holds the auto-init select pin sampled at master reset release.
// - Status bit 13 high means auto-initialization ran after master reset.
// - Soft reset bit 10 stays high until reset actions end, then clears and ready rises.
module rt_status_ctrl #(
	parameter int CUT_CYCLES = rt_status_pkg::WDT_CUT_CYCLES
) (
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire logic        AUTOINIT_SELECT,
	input  wire logic        AUTOINIT_DONE,
	input  wire logic        SOFT_RESET_DONE,
	input  wire logic        BIST_BUSY,
	input  wire logic        WDT_TIMEOUT_A,
	input  wire logic        WDT_TIMEOUT_B,
	input  wire logic        TX_ACTIVE_A,
	input  wire logic        TX_ACTIVE_B,
	input  wire logic        HOST_WR,
	input  wire logic        HOST_RD,
	input  wire logic [15:0] HOST_ADDR,
	input  wire logic [15:0] HOST_WDATA,
	output logic      [15:0] HOST_RDATA,
	output logic             HOST_LOCKED,
	output logic             AUTOINIT_START,
	output logic             SOFT_RESET_START,
	output logic             TX_ALLOW_A,
	output logic             TX_ALLOW_B,
	output logic             READY
);

	rt_status_pkg::ctrl_state_t state_r;
	rt_status_pkg::ctrl_state_t state_nxt;

	logic        asel_latch_r;
	logic        srst_bit_r;
	logic        txinh_en_r;
	logic        ai_start_r;
	logic        sr_start_r;
	logic [15:0] rdata_r;
	logic        ready;
	logic        wr_ok;
	logic        wr_mstat;
	logic        wr_wdcfg;
	logic        srst_req;
	logic [15:0] mstat;
	logic [15:0] wdcfg;
	logic [15:0] rtcfg;
	logic [15:0] rd_word;

	wd_bus_if bus_a ();
	wd_bus_if bus_b ();

	// No flop on ready, so a self test locks the host in the same cycle
	assign ready    = (state_r == rt_status_pkg::ST_RUN) && !BIST_BUSY;
	assign wr_ok    = HOST_WR && ready;
	assign wr_mstat = wr_ok && HOST_ADDR == rt_status_pkg::MSTAT_OFFSET;
	assign wr_wdcfg = wr_ok && HOST_ADDR == rt_status_pkg::WDCFG_OFFSET;
	// Only bit 10 starts a soft reset; bits 12 and 11 are reserved here
	assign srst_req = wr_mstat && HOST_WDATA[rt_status_pkg::MSTAT_SRST_BIT];

	// Latch state lasts one cycle, so the select pin is looked at once
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			rt_status_pkg::ST_LATCH: begin
				state_nxt = AUTOINIT_SELECT ? rt_status_pkg::ST_AUTOINIT
					: rt_status_pkg::ST_RUN;
			end
			rt_status_pkg::ST_AUTOINIT: begin
				if (AUTOINIT_DONE) begin
					state_nxt = rt_status_pkg::ST_RUN;
				end
			end
			rt_status_pkg::ST_RUN: begin
				if (srst_req) begin
					state_nxt = rt_status_pkg::ST_SOFTRST;
				end
			end
			rt_status_pkg::ST_SOFTRST: begin
				if (SOFT_RESET_DONE) begin
					state_nxt = rt_status_pkg::ST_RUN;
				end
			end
			default: begin
				state_nxt = rt_status_pkg::ST_LATCH;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r <= rt_status_pkg::ST_LATCH;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Pin caught on first edge after release, never again
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			asel_latch_r <= 1'b0;
		end else if (state_r == rt_status_pkg::ST_LATCH) begin
			asel_latch_r <= AUTOINIT_SELECT;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			srst_bit_r <= 1'b0;
		end else begin
			srst_bit_r <= (state_nxt == rt_status_pkg::ST_SOFTRST);
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ai_start_r <= 1'b0;
		end else begin
			ai_start_r <= (state_r == rt_status_pkg::ST_LATCH) && AUTOINIT_SELECT;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sr_start_r <= 1'b0;
		end else begin
			sr_start_r <= (state_r == rt_status_pkg::ST_RUN) && srst_req;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			txinh_en_r <= rt_status_pkg::WDCFG_RESET[rt_status_pkg::WDCFG_TXINH_BIT];
		end else if (wr_wdcfg) begin
			txinh_en_r <= HOST_WDATA[rt_status_pkg::WDCFG_TXINH_BIT];
		end
	end

	always_comb begin
		mstat = rt_status_pkg::MSTAT_RESET;
		mstat[rt_status_pkg::MSTAT_READY_BIT] = ready;
		mstat[rt_status_pkg::MSTAT_ASEL_BIT]  = asel_latch_r;
		mstat[rt_status_pkg::MSTAT_SRST_BIT]  = srst_bit_r;
	end

	always_comb begin
		wdcfg = '0;
		wdcfg[rt_status_pkg::WDCFG_TXINH_BIT] = txinh_en_r;
	end

	always_comb begin
		rtcfg = '0;
		rtcfg[rt_status_pkg::RTCFG_INHA_BIT] = bus_a.inhibited;
		rtcfg[rt_status_pkg::RTCFG_INHB_BIT] = bus_b.inhibited;
	end

	// Locked reads ignore the address, so the host can poll status
	always_comb begin
		rd_word = '0;
		if (!ready) begin
			rd_word = mstat;
		end else begin
			case (HOST_ADDR)
				rt_status_pkg::MSTAT_OFFSET: rd_word = mstat;
				rt_status_pkg::WDCFG_OFFSET: rd_word = wdcfg;
				rt_status_pkg::RTCFG_OFFSET: rd_word = rtcfg;
				default:                     rd_word = '0;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_r <= '0;
		end else if (HOST_RD) begin
			rdata_r <= rd_word;
		end
	end

	// Inhibit flags survive until a soft reset clears them
	assign bus_a.timeout    = WDT_TIMEOUT_A;
	assign bus_a.tx_active  = TX_ACTIVE_A;
	assign bus_a.inhibit_en = txinh_en_r;
	assign bus_a.clear      = sr_start_r;

	assign bus_b.timeout    = WDT_TIMEOUT_B;
	assign bus_b.tx_active  = TX_ACTIVE_B;
	assign bus_b.inhibit_en = txinh_en_r;
	assign bus_b.clear      = sr_start_r;

	// One guard per bus; both share the enable and the soft reset clear
	wd_tx_guard #(.CUT_CYCLES(CUT_CYCLES)) u_guard_a (
		.clk    (CLK),
		.arst_n (ARST_N),
		.bus    (bus_a.unit)
	);

	wd_tx_guard #(.CUT_CYCLES(CUT_CYCLES)) u_guard_b (
		.clk    (CLK),
		.arst_n (ARST_N),
		.bus    (bus_b.unit)
	);

	assign TX_ALLOW_A       = bus_a.tx_allow;
	assign TX_ALLOW_B       = bus_b.tx_allow;
	assign READY            = ready;
	assign HOST_LOCKED      = !ready;
	assign HOST_RDATA       = rdata_r;
	assign AUTOINIT_START   = ai_start_r;
	assign SOFT_RESET_START = sr_start_r;
endmodule : rt_status_ctrl

/* rt_status_pkg.sv */
package rt_status_pkg;
	localparam int          CLK_PERIOD_PS    = 8000;
	localparam int          WDT_CUT_US       = 663;
	localparam int          WDT_CUT_CYCLES   = (WDT_CUT_US * 1000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int          ADDR_W           = 16;
	localparam int          DATA_W           = 16;
	localparam logic [15:0] MSTAT_OFFSET     = 16'h0001;
	localparam logic [15:0] WDCFG_OFFSET     = 16'h0004;
	localparam logic [15:0] RTCFG_OFFSET     = 16'h0017;
	localparam int          MSTAT_READY_BIT  = 15;
	localparam int          MSTAT_ASEL_BIT   = 13;
	localparam int          MSTAT_SRST_BIT   = 10;
	localparam int          WDCFG_TXINH_BIT  = 2;
	localparam int          RTCFG_INHA_BIT   = 13;
	localparam int          RTCFG_INHB_BIT   = 12;
	localparam logic [15:0] MSTAT_RESET      = 16'h0000;
	localparam logic [15:0] WDCFG_RESET      = 16'h0000;

	typedef enum logic [1:0] {
		ST_LATCH,
		ST_AUTOINIT,
		ST_RUN,
		ST_SOFTRST
	} ctrl_state_t;
endpackage : rt_status_pkg

/* rt_status_properties.sv */
`timescale 1ns/100ps
module rt_status_properties #(
	parameter int CUT_CYCLES = 20
) (
	input wire logic        CLK,
	input wire logic        ARST_N,
	input wire logic        READY,
	input wire logic        HOST_LOCKED,
	input wire logic        HOST_WR,
	input wire logic        HOST_RD,
	input wire logic        BIST_BUSY,
	input wire logic        WDT_TIMEOUT_A,
	input wire logic        WDT_TIMEOUT_B,
	input wire logic        TX_ACTIVE_A,
	input wire logic        TX_ALLOW_A,
	input wire logic        TX_ALLOW_B,
	input wire logic        SOFT_RESET_START,
	input wire logic        SOFT_RESET_DONE,
	input wire logic [15:0] HOST_ADDR,
	input wire logic [15:0] HOST_WDATA,
	input wire logic [15:0] HOST_RDATA
);
	logic en_r;
	logic srst_r;
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// Shadow enable: only writes taken while ready count
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) en_r <= 1'b0;
		else if (HOST_WR && READY && HOST_ADDR == 16'h0004) en_r <= HOST_WDATA[2];
	end
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) srst_r <= 1'b0;
		else if (SOFT_RESET_START) srst_r <= 1'b1;
		else if (SOFT_RESET_DONE) srst_r <= 1'b0;
	end
	sequence cut_arm;
		WDT_TIMEOUT_A && !en_r ##CUT_CYCLES TX_ACTIVE_A;
	endsequence
	sequence srst_begin;
		$rose(SOFT_RESET_START);
	endsequence
	a_lock_mirror: assert property (HOST_LOCKED == !READY)
		else $error("lock differs from ready");
	a_bist_low: assert property (BIST_BUSY |-> !READY)
		else $error("ready during self test");
	a_locked_read: assert property (HOST_RD && !READY |=> (HOST_RDATA & 16'hdbff) == 16'h0000)
		else $error("locked read not status");
	a_ready_read: assert property (HOST_RD && READY && HOST_ADDR == 16'h0001
		|=> HOST_RDATA[15:14] == 2'b10 && HOST_RDATA[12:10] == 3'b000)
		else $error("status read wrong");
	a_wr_blocked: assert property (HOST_WR && !READY |=> !SOFT_RESET_START)
		else $error("locked write acted");
	a_srst_low: assert property (srst_begin |-> !READY ##1 !READY)
		else $error("ready during soft reset");
	a_srst_end: assert property (srst_r && SOFT_RESET_DONE && !BIST_BUSY |=> READY)
		else $error("ready late after soft reset");
	a_inhibit_a: assert property (WDT_TIMEOUT_A && en_r |=> !TX_ALLOW_A)
		else $error("bus a not inhibited");
	a_inhibit_b: assert property (WDT_TIMEOUT_B && en_r |=> !TX_ALLOW_B)
		else $error("bus b not inhibited");
	a_cut_once: assert property (cut_arm |-> TX_ALLOW_A ##1 !TX_ALLOW_A)
		else $error("cut timing wrong");
endmodule : rt_status_properties

/* test_rt_status_ctrl.sv */
`timescale 1ns/100ps
module test_rt_status_ctrl;
	localparam int CUT_CYCLES = 20;
	logic CLK = 0, ARST_N = 0, AUTOINIT_SELECT = 0, AUTOINIT_DONE = 0, SOFT_RESET_DONE = 0;
	logic BIST_BUSY = 0, WDT_TIMEOUT_A = 0, WDT_TIMEOUT_B = 0, TX_ACTIVE_A = 0, TX_ACTIVE_B = 0;
	logic        HOST_WR, HOST_RD, HOST_LOCKED, AUTOINIT_START, SOFT_RESET_START;
	logic        TX_ALLOW_A, TX_ALLOW_B, READY;
	logic [15:0] HOST_ADDR, HOST_WDATA, HOST_RDATA, q;
	int          err_count = 0, n_compared = 0, seed = 36, n, starts;
	rt_status_ctrl #(.CUT_CYCLES(CUT_CYCLES)) dut (
		.CLK              (CLK),
		.ARST_N           (ARST_N),
		.AUTOINIT_SELECT  (AUTOINIT_SELECT),
		.AUTOINIT_DONE    (AUTOINIT_DONE),
		.SOFT_RESET_DONE  (SOFT_RESET_DONE),
		.BIST_BUSY        (BIST_BUSY),
		.WDT_TIMEOUT_A    (WDT_TIMEOUT_A),
		.WDT_TIMEOUT_B    (WDT_TIMEOUT_B),
		.TX_ACTIVE_A      (TX_ACTIVE_A),
		.TX_ACTIVE_B      (TX_ACTIVE_B),
		.HOST_WR          (HOST_WR),
		.HOST_RD          (HOST_RD),
		.HOST_ADDR        (HOST_ADDR),
		.HOST_WDATA       (HOST_WDATA),
		.HOST_RDATA       (HOST_RDATA),
		.HOST_LOCKED      (HOST_LOCKED),
		.AUTOINIT_START   (AUTOINIT_START),
		.SOFT_RESET_START (SOFT_RESET_START),
		.TX_ALLOW_A       (TX_ALLOW_A),
		.TX_ALLOW_B       (TX_ALLOW_B),
		.READY            (READY)
	);
	rt_host_model host (
		.CLK        (CLK),
		.READY      (READY),
		.HOST_RDATA (HOST_RDATA),
		.HOST_WR    (HOST_WR),
		.HOST_RD    (HOST_RD),
		.HOST_ADDR  (HOST_ADDR),
		.HOST_WDATA (HOST_WDATA)
	);
	initial forever #4 CLK = ~CLK;
	always @(posedge CLK) if (AUTOINIT_START === 1'b1) starts++;
	function automatic logic [15:0] stat(input logic rdy, sel, srst);
		return {rdy, 1'b0, sel, 2'b00, srst, 10'h000};
	endfunction : stat
	task check(input string what, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done
	initial begin
		#200000;
		err_count++;
		test_done;
	end
	initial begin
		for (int k = 0; k < 2; k++) begin
			@(posedge CLK);
			ARST_N <= 1'b0;
			AUTOINIT_SELECT <= k[0];
			repeat (20) @(posedge CLK);
			starts = 0;
			ARST_N <= 1'b1;
			@(posedge CLK);
			// Pin moves only after the latch edge
			AUTOINIT_SELECT <= !k[0];
			if (k == 1) begin
				host.req(1'b0, 16'($random(seed)), 16'h0000, 1'b0, q);
				check("init read", q, stat(0, 1, 0));
				@(posedge CLK);
				AUTOINIT_DONE <= 1'b1;
				@(posedge CLK);
				AUTOINIT_DONE <= 1'b0;
			end
			host.req(1'b0, 16'h0001, 16'h0000, 1'b1, q);
			check("status", q, stat(1, k[0], 0));
			check("starts", 16'(starts), 16'(k));
			$display("test reset %0d done", k);
		end
		@(posedge CLK);
		BIST_BUSY <= 1'b1;
		host.req(1'b1, 16'h0001, 16'h0400, 1'b0, q);
		host.req(1'b0, 16'($random(seed)), 16'h0000, 1'b0, q);
		check("test read", q, stat(0, 1, 0));
		@(posedge CLK);
		BIST_BUSY <= 1'b0;
		host.req(1'b0, 16'h0001, 16'h0000, 1'b1, q);
		check("after test", q, stat(1, 1, 0));
		host.req(1'b1, 16'h0001, 16'h0400, 1'b1, q);
		host.req(1'b1, 16'h0004, 16'h0004, 1'b0, q);
		host.req(1'b0, 16'($random(seed)), 16'h0000, 1'b0, q);
		check("srst read", q, stat(0, 1, 1));
		@(posedge CLK);
		SOFT_RESET_DONE <= 1'b1;
		@(posedge CLK);
		SOFT_RESET_DONE <= 1'b0;
		host.req(1'b0, 16'h0001, 16'h0000, 1'b1, q);
		check("srst end", q, stat(1, 1, 0));
		host.req(1'b0, 16'h0004, 16'h0000, 1'b1, q);
		check("locked cfg", q, 16'h0000);
		host.req(1'b1, 16'h0004, 16'($random(seed)) & 16'hfffb, 1'b1, q);
		host.req(1'b0, 16'h0004, 16'h0000, 1'b1, q);
		check("cfg zero", q, 16'h0000);
		$display("test soft reset done");
		@(posedge CLK);
		{TX_ACTIVE_A, TX_ACTIVE_B} <= 2'b11;
		{WDT_TIMEOUT_A, WDT_TIMEOUT_B} <= 2'b11;
		@(posedge CLK);
		{WDT_TIMEOUT_A, WDT_TIMEOUT_B} <= 2'b00;
		n = 0;
		do begin
			@(negedge CLK);
			n++;
		end while (TX_ALLOW_A === 1'b1 && n < 100);
		check("cut", 16'(n), 16'(CUT_CYCLES + 1));
		check("cut b", 16'(TX_ALLOW_B), 16'h0000);
		@(posedge CLK);
		{TX_ACTIVE_A, TX_ACTIVE_B} <= 2'b00;
		repeat (2) @(posedge CLK);
		{TX_ACTIVE_A, TX_ACTIVE_B} <= 2'b11;
		repeat (CUT_CYCLES + 5) @(negedge CLK);
		check("next tx", 16'({TX_ALLOW_A, TX_ALLOW_B}), 16'h0003);
		host.req(1'b1, 16'h0004, 16'h0007, 1'b1, q);
		host.req(1'b0, 16'h0004, 16'h0000, 1'b1, q);
		check("cfg", q, 16'h0004);
		for (int i = 0; i < 2; i++) begin
			@(posedge CLK);
			WDT_TIMEOUT_B <= (i == 0);
			WDT_TIMEOUT_A <= (i == 1);
			@(posedge CLK);
			{WDT_TIMEOUT_A, WDT_TIMEOUT_B} <= 2'b00;
			@(negedge CLK);
			check("allow", 16'({TX_ALLOW_A, TX_ALLOW_B}), 16'({i == 0, 1'b0}));
			host.req(1'b0, 16'h0017, 16'h0000, 1'b1, q);
			check("inhibit", q, i ? 16'h3000 : 16'h1000);
		end
		$display("test watchdog done");
		test_done;
	end
endmodule : test_rt_status_ctrl
bind rt_status_ctrl rt_status_properties #(.CUT_CYCLES(CUT_CYCLES)) props (
	.CLK              (CLK),
	.ARST_N           (ARST_N),
	.READY            (READY),
	.HOST_LOCKED      (HOST_LOCKED),
	.HOST_WR          (HOST_WR),
	.HOST_RD          (HOST_RD),
	.BIST_BUSY        (BIST_BUSY),
	.WDT_TIMEOUT_A    (WDT_TIMEOUT_A),
	.WDT_TIMEOUT_B    (WDT_TIMEOUT_B),
	.TX_ACTIVE_A      (TX_ACTIVE_A),
	.TX_ALLOW_A       (TX_ALLOW_A),
	.TX_ALLOW_B       (TX_ALLOW_B),
	.SOFT_RESET_START (SOFT_RESET_START),
	.SOFT_RESET_DONE  (SOFT_RESET_DONE),
	.HOST_ADDR        (HOST_ADDR),
	.HOST_WDATA       (HOST_WDATA),
	.HOST_RDATA       (HOST_RDATA)
);

/* wd_bus_if.sv */
`timescale 1ns/100ps
interface wd_bus_if;
	logic timeout;
	logic tx_active;
	logic inhibit_en;
	logic clear;
	logic inhibited;
	logic tx_allow;

	modport unit (
		input  timeout,
		input  tx_active,
		input  inhibit_en,
		input  clear,
		output inhibited,
		output tx_allow
	);
	modport ctrl (
		output timeout,
		output tx_active,
		output inhibit_en,
		output clear,
		input  inhibited,
		input  tx_allow
	);
endinterface : wd_bus_if

/* wd_tx_guard.sv */
`timescale 1ns/100ps
module wd_tx_guard #(
	parameter int CUT_CYCLES = rt_status_pkg::WDT_CUT_CYCLES
) (
	input  wire logic clk,
	input  wire logic arst_n,
	wd_bus_if.unit    bus
);
	localparam int CW = $clog2(CUT_CYCLES + 1);

	logic          inhibited_r;
	logic          armed_r;
	logic          cut_r;
	logic [CW-1:0] cnt_r;

	// Set wins over clear so a timeout during soft reset is kept
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			inhibited_r <= 1'b0;
		end else if (bus.timeout && bus.inhibit_en) begin
			inhibited_r <= 1'b1;
		end else if (bus.clear) begin
			inhibited_r <= 1'b0;
		end
	end

	// Without inhibit, one cut of the running transmission only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			armed_r <= 1'b0;
			cnt_r   <= '0;
		end else if (bus.timeout && !bus.inhibit_en) begin
			armed_r <= 1'b1;
			cnt_r   <= CW'(CUT_CYCLES - 1);
		end else if (armed_r && cnt_r != '0) begin
			cnt_r <= cnt_r - CW'(1);
		end else if (armed_r) begin
			armed_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cut_r <= 1'b0;
		end else if (armed_r && cnt_r == '0 && bus.tx_active) begin
			cut_r <= 1'b1;
		end else if (!bus.tx_active) begin
			cut_r <= 1'b0;
		end
	end

	assign bus.inhibited = inhibited_r;
	assign bus.tx_allow  = !inhibited_r && !cut_r;
endmodule : wd_tx_guard
